// File: inc/oc_pkg.sv
/*
  Shared constants and types for the output compare channel: register
  offsets, field positions, reset values, mode codes and bus responses.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package oc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00; // Channel control
  localparam logic [7:0] CMP_PRI_OFF = 8'h04; // Primary compare value
  localparam logic [7:0] CMP_SEC_OFF = 8'h08; // Secondary compare value
  localparam logic [7:0] STAT_OFF = 8'h0C; // Pin and pulse state

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IDLE_BIT = 13; // Halt in CPU idle
  localparam int FAULT_BIT = 4; // PWM fault status, read only
  localparam int TSEL_BIT = 3; // Time base select
  localparam int MODE_LSB = 0; // Mode field, three bits
  localparam int PIN_BIT = 0; // Status: present pin level
  localparam int DONE_BIT = 1; // Status: single pulse finished

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0; // Channel disabled
  localparam logic [2:0] MODE_SET_HI = 3'h1; // Start low, event drives high
  localparam logic [2:0] MODE_SET_LO = 3'h2; // Start high, event drives low
  localparam logic [2:0] MODE_TOGGLE = 3'h3; // Event inverts the pin
  localparam logic [2:0] MODE_ONE_PULSE = 3'h4; // One pulse, then idle
  localparam logic [2:0] MODE_PULSES = 3'h5; // Pulse every period
  localparam logic [2:0] MODE_PWM = 3'h6; // PWM, fault ignored
  localparam logic [2:0] MODE_PWM_FLT = 3'h7; // PWM, fault honoured

  // ----------------------------------------------------------------
  // Reset values and bus responses
  // ----------------------------------------------------------------
  localparam logic [15:0] CMP_RESET = 16'h0000; // Compare registers
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal access
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

  // Software-written control fields
  typedef struct packed {
    logic idleStop; // Halt while the CPU idles
    logic tsel; // 1 = timebase three, 0 = timebase two
    logic [2:0] mode; // Compare mode field
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{idleStop: 1'b0, tsel: 1'b0, mode: MODE_OFF};

endpackage : oc_pkg

// File: design/output_compare_channel.sv
/*
  One output compare channel with an AXI4-Lite register slave.
  Assumes both shared timebase counts come from logic on clk, that
  cpuIdle is a level on clk, and that the fault input is an
  asynchronous pin.
*/
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
// How it works
// - Idle-stop bit halts channel during CPU idle
// - Fault bit set by hardware, cleared by hardware
// - Fault bit reports only in PWM-with-fault mode
// - Time-base bit picks timebase three or two
// - Mode 111: PWM with fault input active
// - Mode 110: PWM, fault input ignored
// - Mode 101: start low, pulse every period
// - Mode 100: start low, exactly one pulse
// - Mode 011: compare event toggles the pin
// - Mode 010: start high, event forces low
// - Mode 001: start low, event forces high
// - Mode 000: channel disabled, no activity
`timescale 1ns/1ns
module output_compare_channel
  import oc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpuIdle,
  input wire logic [15:0] timebaseTwoCount,
  input wire logic [15:0] timebaseThreeCount,
  input wire logic faultIn,
  output logic compareOutputPin,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctrl_t ctrl_q; // Software control fields
  logic fault_q; // PWM fault status
  logic [15:0] cmpPri_q; // Rising or event compare value
  logic [15:0] cmpSec_q; // Falling compare value for pulse modes
  logic pin_q; // Output pin level
  logic done_q; // Single pulse has ended
  logic faultMeta_q; // First synchroniser stage
  logic faultSync_q; // Synchronised fault level
  logic matchPrev_q; // Primary match one cycle ago
  logic secPrev_q; // Secondary match one cycle ago
  logic zeroPrev_q; // Count was zero one cycle ago
  logic awHeld_q, wHeld_q; // Write halves captured
  logic [7:0] awAddr_q; // Captured write address
  logic [31:0] wData_q; // Captured write data
  logic [3:0] wStrb_q; // Captured byte enables
  logic awHeld_d, wHeld_d;
  logic [31:0] rdMux; // Read data selected by address
  logic rdHit; // Read address is mapped
  logic [15:0] selCount; // Count of the chosen time base
  logic halt, running, matchPri, matchSec, atZero;
  logic evPri, evSec, evZero, doWrite, ctrlWr, wrHit;

  // ----------------------------------------------------------------
  // Compare events
  // ----------------------------------------------------------------
  // Time base choice
  assign selCount = ctrl_q.tsel ? timebaseThreeCount : timebaseTwoCount;
  assign halt = ctrl_q.idleStop && cpuIdle;
  assign running = (ctrl_q.mode != MODE_OFF) && !halt;
  assign matchPri = (selCount == cmpPri_q);
  assign matchSec = (selCount == cmpSec_q);
  assign atZero = (selCount == 16'h0000);
  // A prescaled timer can sit on one value for many cycles, so only
  // the first cycle of a match counts as an event.
  assign evPri = running && matchPri && !matchPrev_q;
  assign evSec = running && matchSec && !secPrev_q;
  assign evZero = running && atZero && !zeroPrev_q;

  // Match history, tracked even while halted so resuming is quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      matchPrev_q <= 1'b0;
      secPrev_q <= 1'b0;
      zeroPrev_q <= 1'b0;
    end else begin
      matchPrev_q <= matchPri;
      secPrev_q <= matchSec;
      zeroPrev_q <= atZero;
    end
  end

  // Fault pin synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultMeta_q <= 1'b0;
      faultSync_q <= 1'b0;
    end else begin
      faultMeta_q <= faultIn;
      faultSync_q <= faultMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Fault status
  // ----------------------------------------------------------------
  // Set wins over clear; cleared by hardware only, at a period start
  // once the fault has gone, or when the mode leaves PWM-with-fault.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_q <= 1'b0;
    end else if ((ctrl_q.mode == MODE_PWM_FLT) && faultSync_q) begin
      fault_q <= 1'b1;
    end else if (ctrl_q.mode != MODE_PWM_FLT) begin
      fault_q <= 1'b0;
    end else if (evZero) begin
      fault_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // A write of the mode field sets the starting level of the pin.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else if (ctrlWr && wStrb_q[0]) begin
      pin_q <= (wData_q[MODE_LSB +: 3] == MODE_SET_LO);
    end else if (!halt) begin
      case (ctrl_q.mode)
        MODE_OFF: pin_q <= 1'b0;
        MODE_SET_HI: if (evPri) pin_q <= 1'b1;
        MODE_SET_LO: if (evPri) pin_q <= 1'b0;
        MODE_TOGGLE: if (evPri) pin_q <= !pin_q;
        MODE_ONE_PULSE, MODE_PULSES: begin
          // Rise at the primary value, fall at the secondary one
          if (evPri && !(ctrl_q.mode == MODE_ONE_PULSE && done_q)) begin
            pin_q <= 1'b1;
          end else if (evSec) begin
            pin_q <= 1'b0;
          end
        end
        default: begin
          // PWM: high at period start, low at the duty value
          if (ctrl_q.mode == MODE_PWM_FLT && (fault_q || faultSync_q)) begin
            pin_q <= 1'b0;
          end else if (evPri) begin
            pin_q <= 1'b0;
          end else if (evZero) begin
            pin_q <= (cmpPri_q != 16'h0000);
          end
        end
      endcase
    end
  end

  // Single pulse bookkeeping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (ctrlWr && wStrb_q[0]) begin
      done_q <= 1'b0;
    end else if (ctrl_q.mode == MODE_ONE_PULSE && evSec && pin_q) begin
      done_q <= 1'b1;
    end
  end

  assign compareOutputPin = pin_q;

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  assign doWrite = awHeld_q && wHeld_q && !bvalid;
  assign ctrlWr = doWrite && (awAddr_q == CTRL_OFF);
  assign wrHit = (awAddr_q == CTRL_OFF) || (awAddr_q == CMP_PRI_OFF)
    || (awAddr_q == CMP_SEC_OFF) || (awAddr_q == STAT_OFF);
  // Halves stay held until the response is taken: one write at a time
  assign awHeld_d = (awvalid && awready) || (awHeld_q && !(bvalid && bready));
  assign wHeld_d = (wvalid && wready) || (wHeld_q && !(bvalid && bready));

  // Address and data capture, in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awready <= !awHeld_d;
      wready <= !wHeld_d;
      if (awvalid && awready) awAddr_q <= awaddr;
      if (wvalid && wready) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Register update; the fault bit and status word ignore writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
      cmpPri_q <= CMP_RESET;
      cmpSec_q <= CMP_RESET;
    end else if (doWrite) begin
      if (awAddr_q == CTRL_OFF) begin
        if (wStrb_q[0]) ctrl_q.tsel <= wData_q[TSEL_BIT];
        if (wStrb_q[0]) ctrl_q.mode <= wData_q[MODE_LSB +: 3];
        if (wStrb_q[1]) ctrl_q.idleStop <= wData_q[IDLE_BIT];
      end else if (awAddr_q == CMP_PRI_OFF) begin
        if (wStrb_q[0]) cmpPri_q[7:0] <= wData_q[7:0];
        if (wStrb_q[1]) cmpPri_q[15:8] <= wData_q[15:8];
      end else if (awAddr_q == CMP_SEC_OFF) begin
        if (wStrb_q[0]) cmpSec_q[7:0] <= wData_q[7:0];
        if (wStrb_q[1]) cmpSec_q[15:8] <= wData_q[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  // Read data selection; unmapped words read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    if (araddr == CTRL_OFF) begin
      rdMux[IDLE_BIT] = ctrl_q.idleStop;
      rdMux[FAULT_BIT] = fault_q;
      rdMux[TSEL_BIT] = ctrl_q.tsel;
      rdMux[MODE_LSB +: 3] = ctrl_q.mode;
    end else if (araddr == CMP_PRI_OFF) begin
      rdMux[15:0] = cmpPri_q;
    end else if (araddr == CMP_SEC_OFF) begin
      rdMux[15:0] = cmpSec_q;
    end else if (araddr == STAT_OFF) begin
      rdMux[PIN_BIT] = pin_q;
      rdMux[DONE_BIT] = done_q;
    end else begin
      rdHit = 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sEvent(logic [2:0] m);
    ctrl_q.mode == m && evPri && !ctrlWr && !halt;
  endsequence

  sequence sQuiet;
    !ctrlWr ##1 !ctrlWr;
  endsequence

  idle_halt_hold_a: assert property (halt && !ctrlWr |=> $stable(pin_q))
    else $error("pin moved while halted in idle");
  // A halted channel freezes its pin, so only a running one must drop it
  fault_flag_set_a: assert property (
    ctrl_q.mode == MODE_PWM_FLT && faultSync_q && !ctrlWr && !halt |=> fault_q && !pin_q)
    else $error("fault did not set flag and force pin low");
  fault_mode_only_a: assert property (ctrl_q.mode != MODE_PWM_FLT |=> !fault_q)
    else $error("fault reported outside PWM-with-fault mode");
  timebase_pick_a: assert property (
    evPri |-> (ctrl_q.tsel ? timebaseThreeCount : timebaseTwoCount) == cmpPri_q)
    else $error("event from wrong time base");
  pwm_no_fault_a: assert property (
    ctrl_q.mode == MODE_PWM && evZero && !evPri && cmpPri_q != 16'h0000 && !ctrlWr
    |=> pin_q)
    else $error("PWM period start did not raise pin");
  pulse_rise_a: assert property (sEvent(MODE_PULSES) |=> pin_q)
    else $error("continuous pulse did not rise");
  single_once_a: assert property (
    ctrl_q.mode == MODE_ONE_PULSE && done_q ##0 sQuiet |-> !pin_q)
    else $error("second pulse after single pulse");
  toggle_event_a: assert property (sEvent(MODE_TOGGLE) |=> pin_q != $past(pin_q))
    else $error("toggle event did not invert pin");
  force_low_a: assert property (sEvent(MODE_SET_LO) |=> !pin_q)
    else $error("event did not force pin low");
  force_high_a: assert property (sEvent(MODE_SET_HI) |=> pin_q)
    else $error("event did not force pin high");
  disabled_quiet_a: assert property (
    ctrl_q.mode == MODE_OFF ##1 (ctrl_q.mode == MODE_OFF && !ctrlWr) |=> !pin_q && !evPri)
    else $error("disabled channel active");
  // Once the flag stands the pin stays low until hardware clears it
  fault_hold_low_a: assert property (
    ctrl_q.mode == MODE_PWM_FLT && fault_q && !halt && !ctrlWr |=> !pin_q)
    else $error("pin left low-forced state while fault flag set");
  // A count that sits on the compare value must not fire twice in a row
  event_single_a: assert property (evPri |=> !evPri)
    else $error("compare event repeated on consecutive cycles");

endmodule : output_compare_channel

// File: verification/fault_load_model.sv
/*
  Model of the load on the compare output pin and of the fault source.
  Assumes one clock shared with the channel; faultReq comes from the bench.
*/
`timescale 1ns/1ns
module fault_load_model (
  input wire logic clk,
  input wire logic compareOutputPin,
  input wire logic faultReq,
  output logic faultIn,
  output int rises
);
  logic pinPrev = 1'b0; // Pin level one cycle ago
  initial faultIn = 1'b0; // No fault at power up
  initial rises = 0; // Rising edges seen on the pin

  // ----------------------------------------------------------------
  // Fault pin and edge counter
  // ----------------------------------------------------------------
  // Fault changes just after an edge, like a real board signal
  always @(posedge clk) begin
    faultIn <= faultReq;
    pinPrev <= compareOutputPin;
    // Count rises so quiet modes can be shown to stay quiet
    if (compareOutputPin === 1'b1 && pinPrev === 1'b0) begin
      rises <= rises + 1;
    end
  end
endmodule : fault_load_model

// File: verification/tb.sv
/*
  Self-checking bench for the output compare channel.
  Assumes the timebase counts are free counters made here.
*/
`timescale 1ns/1ns
module tb;
  import oc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, cpuIdle = 1'b0, faultReq = 1'b0;
  logic [15:0] t2Cnt = 16'h0000, t3Cnt = 16'h0000; // Timebase two and three
  logic faultIn, pin, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  int error_cnt = 0, checks = 0, rises;

  always #4 clk = ~clk;
  // Timebase two wraps at 64, three at 256, so only three ever reaches 200
  always @(posedge clk) begin
    t2Cnt <= (t2Cnt + 16'h0001) & 16'h003F;
    t3Cnt <= (t3Cnt + 16'h0001) & 16'h00FF;
  end

  output_compare_channel output_compare_channel_i (.clk(clk), .sys_rst(sys_rst),
    .cpuIdle(cpuIdle), .timebaseTwoCount(t2Cnt), .timebaseThreeCount(t3Cnt),
    .faultIn(faultIn), .compareOutputPin(pin), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  fault_load_model fault_load_model_i (.clk(clk), .compareOutputPin(pin),
    .faultReq(faultReq), .faultIn(faultIn), .rises(rises));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && awready === 1'b1) begin awDone = 1'b1; awvalid <= 1'b0; end
      if (!wDone && wready === 1'b1) begin wDone = 1'b1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Returns in the cycle where the chosen count equals v
  task hit(input logic sel, input logic [15:0] v);
    do begin @(posedge clk); #1; end while ((sel ? t3Cnt : t2Cnt) !== v);
  endtask : hit

  task pinNext(input string what, input logic exp);
    @(posedge clk); #1;
    chk(what, {31'h0, exp}, {31'h0, pin});
  endtask : pinNext

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(CTRL_OFF); chk("ctrl reset", 32'h00000000, d);
    rd(8'h10); chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h00000000, d);
    wr(8'h10, 32'h0000FFFF); chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(STAT_OFF, 32'hFFFFFFFF); chk("status wr resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(STAT_OFF); chk("status ro", 32'h00000000, d);
    $display("done: registers");
  endtask : t_regs

  task t_edges;
    logic [2:0] modes [3] = '{MODE_SET_HI, MODE_SET_LO, MODE_TOGGLE};
    logic inits [3] = '{1'b0, 1'b1, 1'b0};
    int n;
    wr(CMP_PRI_OFF, 32'h00000014);
    rd(CMP_PRI_OFF); chk("primary readback", 32'h00000014, d);
    foreach (modes[i]) begin
      wr(CTRL_OFF, {29'h0, modes[i]}); #1;
      chk("pin init", {31'h0, inits[i]}, {31'h0, pin});
      hit(1'b0, 16'h0014);
      chk("pin at event", {31'h0, inits[i]}, {31'h0, pin});
      pinNext("pin after event", ~inits[i]);
    end
    hit(1'b0, 16'h0014); pinNext("second toggle", 1'b0);
    wr(CTRL_OFF, 32'h00000000); n = rises;
    hit(1'b0, 16'h0014); hit(1'b0, 16'h0014);
    chk("off rises", n, rises);
    chk("off pin", 32'h0, {31'h0, pin});
    $display("done: edge modes");
  endtask : t_edges

  task t_tsel;
    wr(CMP_PRI_OFF, 32'h000000C8); wr(CTRL_OFF, 32'h00000009);
    hit(1'b1, 16'h00C8); chk("tsel before", 32'h0, {31'h0, pin});
    pinNext("tsel after", 1'b1);
    $display("done: timebase select");
  endtask : t_tsel

  task t_pulse;
    wr(CMP_PRI_OFF, 32'h0000000A); wr(CMP_SEC_OFF, 32'h0000001E);
    for (int m = 4; m < 6; m++) begin
      wr(CTRL_OFF, m); #1;
      chk("pulse init", 32'h0, {31'h0, pin});
      hit(1'b0, 16'h000A); pinNext("pulse rise", 1'b1);
      hit(1'b0, 16'h001E); pinNext("pulse fall", 1'b0);
      hit(1'b0, 16'h000A); pinNext("next period", m == 5);
      rd(STAT_OFF); chk("pulse status", {30'h0, m == 4, m == 5}, d);
    end
    $display("done: pulse modes");
  endtask : t_pulse

  task t_pwm;
    wr(CMP_PRI_OFF, 32'h00000028); wr(CTRL_OFF, {29'h0, MODE_PWM});
    hit(1'b0, 16'h0000); pinNext("pwm high", 1'b1);
    @(posedge clk); faultReq <= 1'b1;
    repeat (6) @(posedge clk); #1;
    chk("fault ignored", 32'h1, {31'h0, pin});
    hit(1'b0, 16'h0028); pinNext("pwm low", 1'b0);
    wr(CTRL_OFF, 32'h00000016); rd(CTRL_OFF);
    chk("flag unused", 32'h00000006, d);
    wr(CTRL_OFF, {29'h0, MODE_PWM_FLT}); rd(CTRL_OFF);
    chk("flag set", 32'h00000017, d);
    hit(1'b0, 16'h0000); pinNext("fault pin", 1'b0);
    @(posedge clk); faultReq <= 1'b0;
    repeat (4) @(posedge clk);
    hit(1'b0, 16'h0000); @(posedge clk); rd(CTRL_OFF);
    chk("flag cleared", 32'h00000007, d);
    $display("done: pwm");
  endtask : t_pwm

  task t_idle;
    wr(CMP_PRI_OFF, 32'h00000014);
    @(posedge clk); cpuIdle <= 1'b1;
    wr(CTRL_OFF, 32'h00002003); hit(1'b0, 16'h0014);
    pinNext("halted", 1'b0);
    wr(CTRL_OFF, 32'h00000003); hit(1'b0, 16'h0014);
    pinNext("runs in idle", 1'b1);
    @(posedge clk); cpuIdle <= 1'b0;
    $display("done: idle");
  endtask : t_idle

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs under two thousand cycles; this is ample headroom
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs(); t_edges(); t_tsel(); t_pulse(); t_pwm(); t_idle();
    tally_and_finish();
  end
endmodule : tb
